// ---- pkg/bsfs_pkg.sv ----
// Shared constants, state enumeration and signal bundles of the buck switch fault sequencer.
// Assumes comparator results arrive as synchronous levels and the cycle start as a one-clock pulse.
package bsfs_pkg;

  // Counts in switching cycles
  localparam int unsigned BSFS_HICCUP_WAIT_CYCLES = 512;
  localparam int unsigned BSFS_HICCUP_OFF_CYCLES = 16384;
  localparam int unsigned BSFS_PG_DEGLITCH_CYCLES = 16;

  // Current reference coding
  localparam int unsigned BSFS_LEVEL_W = 8;
  localparam logic [7:0] BSFS_IREF_MAX = 8'hC0;

  // Reset values of the gate commands and of the supply-good output
  localparam logic BSFS_GATE_RST = 1'b0;
  localparam logic BSFS_PG_RST = 1'b0;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_HICCUP} bsfs_state_e;

  // Comparator results, each high when its condition holds
  typedef struct packed {
    logic input_supply_ok;   // Input supply above its lockout level
    logic enable_ok;         // Enable pin above its threshold
    logic fb_above_108;      // Feedback level above 108 % of reference
    logic fb_above_106;      // Feedback level above 106 % of reference
    logic fb_below_89;       // Feedback level below 89 % of reference
    logic ls_source_over;    // Low-side sourcing current above its limit
    logic ls_sink_over;      // Low-side sinking current above its limit
    logic boot_uv;           // Bootstrap voltage below 2.2 V
  } bsfs_cmp_s;

  // Gate commands of the two power switches
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } bsfs_gate_s;

endpackage

// ---- test/bsfs_plant.sv ----
// Power stage stand-in: switch current ramps while the high side conducts.
// Assumes comparator levels come from the bench.
`timescale 1ns/100ps
module bsfs_plant
  import bsfs_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Gate commands
  input wire bsfs_gate_s gate_r,
  // Sensed current
  output logic [BSFS_LEVEL_W-1:0] sense_current
);
  // Rises 16 codes a clock while on; the sensor sees nothing once off
  initial sense_current = 8'h00;
  always @(posedge clk_sys)
  begin
    sense_current <= gate_r.hs_on ? sense_current + 8'h10 : 8'h00;
  end
endmodule

// ---- test/bsfs_top_assertions.sv ----
// Checker of the sequencer gate and status outputs.
// Assumes one clock domain; bound to bsfs_top below.
`timescale 1ns/100ps
module bsfs_top_assertions
  import bsfs_pkg::*;
#(
  parameter int unsigned LEVEL_W = 8,
  parameter logic [LEVEL_W-1:0] IREF_MAX = 8'hC0,
  parameter int unsigned HICCUP_WAIT = 512,
  parameter int unsigned HICCUP_OFF = 16384,
  parameter int unsigned PG_DEGLITCH = 16
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Front end
  input wire logic cycle_start,
  input wire bsfs_cmp_s cmp,
  input wire logic [LEVEL_W-1:0] ea_level,
  input wire logic [LEVEL_W-1:0] sense_current,
  // Results
  input wire bsfs_gate_s gate_r,
  input wire logic supply_ok_output_r,
  input wire logic active_r,
  input wire logic low_iq_r,
  input wire logic hiccup_r
);
  // Clamped reference and mid-cycle on condition
  wire logic pwr = cmp.input_supply_ok & cmp.enable_ok;
  wire logic [LEVEL_W-1:0] iref = (ea_level > IREF_MAX) ? IREF_MAX : ea_level;
  wire logic run = clk_en & pwr & ~cycle_start & gate_r.hs_on;
  wire logic fault = cmp.fb_below_89 | cmp.fb_above_108;
  int wait_n;
  int off_n;
  int pg_n;
  // Start counts kept apart from the design, so a shared slip cannot hide
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst | ~active_r | hiccup_r)
      wait_n <= 0;
    else if (clk_en & cycle_start)
      wait_n <= (ea_level >= IREF_MAX) ? wait_n + 1 : 0;
    if (sys_rst | ~hiccup_r)
      off_n <= 0;
    else if (clk_en & cycle_start)
      off_n <= off_n + 1;
    if (sys_rst | ~pwr | ~fault)
      pg_n <= 0;
    else if (clk_en & cycle_start)
      pg_n <= pg_n + 1;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  excl_gates_a: assert property (!(gate_r.hs_on && gate_r.ls_on))
    else $error("both gates on");
  ovp_off_a: assert property (run && cmp.fb_above_108 |=> gate_r == 2'b01)
    else $error("no overvoltage turn-off");
  peak_off_a: assert property (run && sense_current >= iref |=> gate_r == 2'b01)
    else $error("no peak turn-off");
  boot_off_a: assert property (run && cmp.boot_uv |=> gate_r == 2'b01)
    else $error("no bootstrap turn-off");
  hs_start_a: assert property ($rose(gate_r.hs_on) |->
    $past(cycle_start && !cmp.ls_source_over && !cmp.boot_uv && !cmp.fb_above_108))
    else $error("bad high-side start");
  src_skip_a: assert property (clk_en && cycle_start && !gate_r.hs_on && cmp.ls_source_over |=>
    !gate_r.hs_on) else $error("source limit ignored");
  sink_off_a: assert property (clk_en && pwr && gate_r.ls_on && cmp.ls_sink_over && !cmp.boot_uv
    && !cycle_start |=> gate_r == 2'b00) else $error("sink limit ignored");
  idle_gate_a: assert property (!active_r || low_iq_r || hiccup_r |-> gate_r == 2'b00)
    else $error("switching while idle");
  hic_wait_a: assert property ($rose(hiccup_r) |-> $past(wait_n) == int'(HICCUP_WAIT))
    else $error("hiccup wait wrong");
  hic_off_a: assert property ($fell(hiccup_r) && active_r |-> $past(off_n) == int'(HICCUP_OFF) - 1)
    else $error("hiccup ended early");
  hic_max_a: assert property (hiccup_r |-> off_n < int'(HICCUP_OFF))
    else $error("hiccup too long");
  pg_drop_a: assert property (pg_n >= int'(PG_DEGLITCH) |-> !supply_ok_output_r)
    else $error("supply-good not dropped");
  pg_good_a: assert property (clk_en && pwr && !fault |=> supply_ok_output_r)
    else $error("supply-good not restored");
  // Main scenarios
  cover property ($rose(hiccup_r));
  cover property ($fell(supply_ok_output_r));
  cover property (run && sense_current >= iref);
endmodule

bind bsfs_top bsfs_top_assertions #(.LEVEL_W(LEVEL_W), .IREF_MAX(IREF_MAX), .HICCUP_WAIT(HICCUP_WAIT),
  .HICCUP_OFF(HICCUP_OFF), .PG_DEGLITCH(PG_DEGLITCH)) u_chk (.clk_sys, .sys_rst, .clk_en, .cycle_start,
  .cmp, .ea_level, .sense_current, .gate_r, .supply_ok_output_r, .active_r, .low_iq_r, .hiccup_r);

// ---- test/bsfs_top_tb_top.sv ----
// Bench of the sequencer: comparator levels from tasks, current from the plant.
// Assumes short hiccup and deglitch counts set at the instance.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) \
  begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module bsfs_top_tb_top
  import bsfs_pkg::*;
;
  localparam int OFF = 8;
  logic clk_sys;
  logic sys_rst;
  logic cycle_start;
  bsfs_cmp_s cmp;
  logic [7:0] ea_level;
  logic [7:0] sense_current;
  bsfs_gate_s gate_r;
  logic supply_ok_output_r;
  logic active_r;
  logic low_iq_r;
  logic hiccup_r;
  int err_count;
  int checks_done;
  int k;
  // Short counts keep the run brief
  bsfs_top #(.HICCUP_WAIT(4), .HICCUP_OFF(OFF), .PG_DEGLITCH(2)) dut (.clk_sys, .sys_rst, .clk_en(1'b1),
    .cycle_start, .cmp, .ea_level, .sense_current, .gate_r, .supply_ok_output_r, .active_r, .low_iq_r,
    .hiccup_r);
  bsfs_plant u_plant (.clk_sys, .gate_r, .sense_current);
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse();
    cycle_start = 1'b1;
    tick(1);
    cycle_start = 1'b0;
  endtask
  // Clocks of high-side on time; two spare clocks let the current fall back
  task automatic on_time();
    k = 0;
    while (gate_r.hs_on === 1'b1 && k < 40)
    begin
      tick(1);
      k++;
    end
    tick(2);
  endtask
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_power();
    `CHK("low_iq", 1'b1, low_iq_r)
    cmp.input_supply_ok = 1'b1;
    tick(2);
    `CHK("active", 1'b0, active_r)
    cmp.enable_ok = 1'b1;
    tick(2);
    `CHK("active", 1'b1, active_r)
    `CHK("gates", 2'b01, gate_r)
    `CHK("pg", 1'b1, supply_ok_output_r)
  endtask
  // Above C0 the on time must stop growing
  task automatic t_peak();
    logic [7:0] ea_tab [3] = '{8'h40, 8'hC0, 8'hFF};
    int k_tab [3] = '{5, 13, 13};
    for (int i = 0; i < 3; i++)
    begin
      ea_level = ea_tab[i];
      pulse();
      on_time();
      `CHK("on_clks", k_tab[i], k)
    end
    `CHK("ls", 1'b1, gate_r.ls_on)
  endtask
  task automatic t_ovp();
    ea_level = 8'h80;
    pulse();
    tick(2);
    cmp.fb_above_108 = 1'b1;
    cmp.fb_above_106 = 1'b1;
    tick(1);
    `CHK("ovp_off", 2'b01, gate_r)
    tick(3);
    pulse();
    `CHK("ovp_hold", 1'b0, gate_r.hs_on)
    cmp.fb_above_108 = 1'b0;
    tick(1);
    pulse();
    `CHK("band", 1'b0, gate_r.hs_on)
    cmp.fb_above_106 = 1'b0;
    tick(1);
    `CHK("no_mid", 1'b0, gate_r.hs_on)
    pulse();
    `CHK("resume", 1'b1, gate_r.hs_on)
    on_time();
  endtask
  task automatic t_src();
    cmp.ls_source_over = 1'b1;
    pulse();
    `CHK("skip", 2'b01, gate_r)
    cmp.ls_source_over = 1'b0;
    tick(1);
    `CHK("no_mid", 1'b0, gate_r.hs_on)
    pulse();
    `CHK("resume", 1'b1, gate_r.hs_on)
    on_time();
  endtask
  task automatic t_sink();
    cmp.ls_sink_over = 1'b1;
    tick(1);
    `CHK("sink_off", 2'b00, gate_r)
    cmp.ls_sink_over = 1'b0;
    tick(2);
    `CHK("sink_lock", 2'b00, gate_r)
    pulse();
    `CHK("hs_on", 2'b10, gate_r)
    on_time();
    `CHK("ls_back", 2'b01, gate_r)
    cmp.ls_sink_over = 1'b1;
    tick(1);
    cmp.ls_sink_over = 1'b0;
    cmp.boot_uv = 1'b1;
    tick(1);
    pulse();
    tick(1);
    `CHK("boot_ls", 2'b01, gate_r)
    cmp.boot_uv = 1'b0;
    pulse();
    tick(1);
    cmp.boot_uv = 1'b1;
    tick(1);
    `CHK("boot_off", 2'b01, gate_r)
    cmp.boot_uv = 1'b0;
    tick(3);
  endtask
  // One unclamped start mid-run must restart the wait
  task automatic t_hic();
    for (int i = 0; i < 9; i++)
    begin
      ea_level = (i == 0 || i == 4) ? 8'h20 : 8'hFF;
      pulse();
      on_time();
    end
    `CHK("no_trip", 1'b0, hiccup_r)
    pulse();
    `CHK("trip", 1'b1, hiccup_r)
    `CHK("hic_gates", 2'b00, gate_r)
    ea_level = 8'h20;
    repeat (OFF - 1)
    begin
      pulse();
      tick(1);
    end
    `CHK("still_off", 1'b1, hiccup_r)
    pulse();
    tick(1);
    `CHK("restart", 1'b0, hiccup_r)
    pulse();
    `CHK("run", 1'b1, gate_r.hs_on)
    on_time();
  endtask
  task automatic t_pg();
    cmp.fb_below_89 = 1'b1;
    pulse();
    `CHK("pg_hold", 1'b1, supply_ok_output_r)
    on_time();
    pulse();
    `CHK("pg_low", 1'b0, supply_ok_output_r)
    cmp.fb_below_89 = 1'b0;
    on_time();
    `CHK("pg_back", 1'b1, supply_ok_output_r)
  endtask
  task automatic t_idle();
    pulse();
    cmp.enable_ok = 1'b0;
    tick(1);
    `CHK("en_off", 2'b00, gate_r)
    `CHK("low_iq", 1'b1, low_iq_r)
    tick(2);
    pulse();
    `CHK("en_stop", 2'b00, gate_r)
  endtask
  // Main sequence
  initial
  begin
    err_count = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    cycle_start = 1'b0;
    cmp = '0;
    ea_level = 8'h20;
    tick(20);
    sys_rst = 1'b0;
    tick(1);
    t_power();
    t_peak();
    t_ovp();
    t_src();
    t_sink();
    t_hic();
    t_pg();
    t_idle();
    finish_test();
  end
  // Watchdog: run is well under this
  initial
  begin
    #40000;
    err_count++;
    finish_test();
  end
endmodule

// ---- verilog/bsfs_cycle_counter.sv ----
// Switching-cycle counter with synchronous clear, used for the hiccup wait and off periods.
// Assumes step is a one-clock pulse per switching cycle; clear wins over step.
`timescale 1ns/100ps
module bsfs_cycle_counter
  import bsfs_pkg::*;
#(
  parameter int unsigned WIDTH = 10
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Control
  input wire logic clear,
  input wire logic step,
  // Count
  output logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } bsfs_cnt_s;

  bsfs_cnt_s s_r;
  bsfs_cnt_s s_nxt;

  if (WIDTH < 2 || WIDTH > 24)
  begin : g_width_check
    $error("bsfs_cycle_counter: WIDTH out of range");
  end

  // Saturating count so a stuck step never wraps back to zero
  always_comb
  begin
    s_nxt = s_r;
    if (clear)
      s_nxt.cnt = '0;
    else if (step && s_r.cnt != {WIDTH{1'b1}})
      s_nxt.cnt = s_r.cnt + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      s_r <= '0;
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign count = s_r.cnt;

endmodule

// ---- verilog/bsfs_deglitch.sv ----
// Supply-good deglitch: the output drops after a fault persists for a set number of cycles.
// Assumes step pulses once per switching cycle; force_low drops the output at once.
`timescale 1ns/100ps
module bsfs_deglitch
  import bsfs_pkg::*;
#(
  parameter int unsigned CYCLES = BSFS_PG_DEGLITCH_CYCLES
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Condition
  input wire logic fault,
  input wire logic step,
  input wire logic force_low,
  // Result
  output logic ok_r
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ok;
  } bsfs_dg_s;

  bsfs_dg_s s_r;
  bsfs_dg_s s_nxt;

  if (CYCLES < 1)
  begin : g_cycles_check
    $error("bsfs_deglitch: CYCLES must be at least 1");
  end

  // Fault must be seen on CYCLES consecutive cycle starts before the output falls
  always_comb
  begin
    s_nxt = s_r;
    if (force_low)
    begin
      s_nxt.cnt = '0;
      s_nxt.ok = 1'b0;
    end
    else if (!fault)
    begin
      s_nxt.cnt = '0;
      s_nxt.ok = 1'b1;
    end
    else if (step)
    begin
      if (s_r.cnt == CW'(CYCLES - 1))
        s_nxt.ok = 1'b0;
      else
        s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_r.cnt <= '0;
      s_r.ok <= BSFS_PG_RST;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign ok_r = s_r.ok;

endmodule

// ---- verilog/bsfs_top.sv ----
// Buck switch fault sequencer: decides per switching cycle whether each power switch may conduct.
// Assumes comparator levels and the cycle-start pulse are synchronous to clk_sys.
//
// Overview of operation
// - Feedback above 108 percent turns the high side off and the low side on.
// - After overvoltage, high side returns at next cycle once feedback drops below 106 percent.
// - High side turns off, low side on, when sensed current reaches the reference.
// - The current reference is clamped to a fixed maximum whatever the error level.
// - Error level clamped for more than 512 cycles stops all switching.
// - Hiccup shutdown lasts 16384 cycles, then normal operation restarts automatically.
// - Sourcing limit exceeded at cycle end skips the next high-side pulse, keeps low on.
// - High side resumes only at a cycle start with sourcing current below limit.
// - Sinking limit turns the low side off at once; both off until next cycle.
// - After a sink trip, low side waits for a high-side on-off or bootstrap undervoltage.
// - Active only while input supply and enable comparators both report above threshold.
// - Enable low stops all switching and enters the low quiescent state.
// - Bootstrap below 2.2 V turns the high side off and the low side on.
// - Supply-good falls after 16 cycles of feedback below 89 or above 108 percent.
`timescale 1ns/100ps
module bsfs_top
  import bsfs_pkg::*;
#(
  parameter int unsigned LEVEL_W = BSFS_LEVEL_W,
  parameter logic [LEVEL_W-1:0] IREF_MAX = LEVEL_W'(BSFS_IREF_MAX),
  parameter int unsigned HICCUP_WAIT = BSFS_HICCUP_WAIT_CYCLES,
  parameter int unsigned HICCUP_OFF = BSFS_HICCUP_OFF_CYCLES,
  parameter int unsigned PG_DEGLITCH = BSFS_PG_DEGLITCH_CYCLES
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Switching-cycle timing
  input wire logic cycle_start,
  // Analog front end
  input wire bsfs_cmp_s cmp,
  input wire logic [LEVEL_W-1:0] ea_level,
  input wire logic [LEVEL_W-1:0] sense_current,
  // Gate commands and status
  output bsfs_gate_s gate_r,
  output logic supply_ok_output_r,
  output logic active_r,
  output logic low_iq_r,
  output logic hiccup_r
);

  localparam int unsigned WAIT_W = $clog2(HICCUP_WAIT + 1);
  localparam int unsigned OFF_W = $clog2(HICCUP_OFF + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(HICCUP_WAIT);
  localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(HICCUP_OFF - 1);

  // Timing model of this block
  // Every decision is taken on a rising clk_sys with clk_en high
  // Gate commands change one clock after the inputs that cause them
  // The high side may only be switched on in a clock that carries cycle_start
  // Turn-off of the high side may happen in any clock of the cycle
  // A low clk_en freezes the sequencer, both counters and the deglitch alike
  //
  // Counts are kept in switching cycles, not in clk_sys periods
  // Both counters therefore step on cycle_start only
  // The clamp wait trips on the start after HICCUP_WAIT clamped starts
  // This reads "more than the wait time" as one extra clamped start
  // The off counter releases hiccup on its HICCUP_OFF-th start
  //
  // Limitations a user must know
  // There is no soft start: RUN is entered on the first powered clock
  // Comparator levels are taken as already synchronous to clk_sys
  // A peak hit seen at cycle_start blocks that cycle's turn-on
  // A sink trip in the same clock as bootstrap undervoltage is not recorded
  // Supply-good recovers at once; only its falling edge is deglitched

  typedef struct packed {
    bsfs_state_e st;
    logic hs;
    logic ls;
    logic overvoltage_guard;        // Overvoltage guard holding the high side off
    logic sink_cyc;   // Sink trip: both off until the cycle ends
    logic sink_lock;  // Sink trip: low side barred until released
    logic active;
    logic low_iq;
    logic hiccup;     // Registered copy of the hiccup state for the output
  } bsfs_top_s;

  bsfs_top_s s_r;
  bsfs_top_s s_nxt;

  logic [WAIT_W-1:0] clamp_cnt;
  logic [OFF_W-1:0] off_cnt;
  logic powered;
  logic clamped;
  logic [LEVEL_W-1:0] iref;
  logic peak_hit;
  logic clamp_clear;
  logic clamp_step;
  logic off_clear;
  logic off_step;
  logic pg_fault;
  logic pg_ok;

  if (LEVEL_W < 2 || LEVEL_W > 16)
  begin : g_level_check
    $error("bsfs_top: LEVEL_W out of range");
  end
  if (HICCUP_WAIT < 1 || HICCUP_OFF < 2)
  begin : g_count_check
    $error("bsfs_top: hiccup counts too small");
  end

  // Enable and lockout comparators together gate all activity
  assign powered = cmp.input_supply_ok & cmp.enable_ok;

  // Reference clamp: the peak current reference can never exceed IREF_MAX
  assign clamped = (ea_level >= IREF_MAX);
  assign iref = clamped ? IREF_MAX : ea_level;
  assign peak_hit = (sense_current >= iref);

  // Clamp wait counts consecutive clamped cycle starts while running
  assign clamp_clear = (s_r.st != ST_RUN) | (cycle_start & ~clamped);
  assign clamp_step = cycle_start & clamped;

  // Off-period counter runs only during hiccup
  assign off_clear = (s_r.st != ST_HICCUP);
  assign off_step = cycle_start;

  bsfs_cycle_counter #(
    .WIDTH(WAIT_W)
  ) u_clamp_wait (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clear(clamp_clear),
    .step(clamp_step),
    .count(clamp_cnt)
  );

  bsfs_cycle_counter #(
    .WIDTH(OFF_W)
  ) u_hiccup_off (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clear(off_clear),
    .step(off_step),
    .count(off_cnt)
  );

  // Supply-good monitor; drops at once when not powered
  assign pg_fault = cmp.fb_below_89 | cmp.fb_above_108;

  bsfs_deglitch #(
    .CYCLES(PG_DEGLITCH)
  ) u_pg_deglitch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .fault(pg_fault),
    .step(cycle_start),
    .force_low(~powered),
    .ok_r(pg_ok)
  );

  // Sequencer: state, overvoltage guard, sink bookkeeping and gate decisions
  // Every path starts from the held state, so a missing assignment keeps a value
  // The low side is derived from the final high-side choice of the same clock
  // That keeps the two commands exclusive even when several faults coincide
  // Later statements override earlier ones, so the order below is the priority:
  // gate decision, sink bookkeeping, hiccup entry, loss of power
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.active = powered;
    s_nxt.low_iq = ~cmp.enable_ok;
    case (s_r.st)
      ST_OFF:
      begin
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
        s_nxt.overvoltage_guard = 1'b0;
        s_nxt.sink_cyc = 1'b0;
        s_nxt.sink_lock = 1'b0;
        if (powered)
          s_nxt.st = ST_RUN;
      end
      ST_RUN:
      begin
        // Overvoltage guard with hysteresis between 108 and 106 percent
        if (cmp.fb_above_108)
          s_nxt.overvoltage_guard = 1'b1;
        else if (!cmp.fb_above_106)
          s_nxt.overvoltage_guard = 1'b0;
        if (cycle_start)
        begin
          s_nxt.sink_cyc = 1'b0;
          // Turn-on happens only here, so a released guard acts at the next cycle
          s_nxt.hs = ~s_nxt.overvoltage_guard & ~cmp.ls_source_over & ~cmp.boot_uv & ~peak_hit;
        end
        else if (s_r.hs && (peak_hit || cmp.fb_above_108 || cmp.boot_uv))
          s_nxt.hs = 1'b0;
        // Release is evaluated before a new trip, so a trip in the same clock wins
        // A completed high-side pulse or bootstrap refresh releases the sink bar
        if ((s_r.hs && !s_nxt.hs) || cmp.boot_uv)
          s_nxt.sink_lock = 1'b0;
        if (s_r.ls && cmp.ls_sink_over && !cmp.boot_uv)
        begin
          s_nxt.sink_cyc = 1'b1;
          s_nxt.sink_lock = 1'b1;
        end
        // Low side follows the high side off, unless a sink trip bars it
        // This also keeps the low side on through a skipped pulse
        s_nxt.ls = ~s_nxt.hs & ~s_nxt.sink_cyc & ~s_nxt.sink_lock;
        // Hiccup entry only at a cycle start, so a partial cycle never counts
        if (cycle_start && clamped && clamp_cnt == WAIT_LAST)
        begin
          s_nxt.st = ST_HICCUP;
          s_nxt.hs = 1'b0;
          s_nxt.ls = 1'b0;
        end
        if (!powered)
        begin
          s_nxt.st = ST_OFF;
          s_nxt.hs = 1'b0;
          s_nxt.ls = 1'b0;
        end
      end
      // Off period: all protection state is wiped so restart begins clean
      ST_HICCUP:
      begin
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
        s_nxt.overvoltage_guard = 1'b0;
        s_nxt.sink_cyc = 1'b0;
        s_nxt.sink_lock = 1'b0;
        if (!powered)
          s_nxt.st = ST_OFF;
        else if (cycle_start && off_cnt == OFF_LAST)
          s_nxt.st = ST_RUN;
      end
      default:
      begin
        s_nxt.st = ST_OFF;
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
      end
    endcase
    // Final guard against shoot-through whatever path was taken
    if (s_nxt.hs)
      s_nxt.ls = 1'b0;
    // Status flag registered so the output comes straight from a flip-flop
    s_nxt.hiccup = (s_nxt.st == ST_HICCUP);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_r.st <= ST_OFF;
      s_r.hs <= BSFS_GATE_RST;
      s_r.ls <= BSFS_GATE_RST;
      s_r.overvoltage_guard <= 1'b0;
      s_r.sink_cyc <= 1'b0;
      s_r.sink_lock <= 1'b0;
      s_r.active <= 1'b0;
      s_r.low_iq <= 1'b1;
      s_r.hiccup <= 1'b0;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  // Outputs come straight from state flip-flops
  assign gate_r.hs_on = s_r.hs;
  assign gate_r.ls_on = s_r.ls;
  assign supply_ok_output_r = pg_ok;
  assign active_r = s_r.active;
  assign low_iq_r = s_r.low_iq;
  assign hiccup_r = s_r.hiccup;

endmodule
